/* psg_pkg.sv */
package psg_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_GEN = 8;
	localparam int MAX_SEC = 100;
	localparam int VAL_W = 16;
	localparam int SEC_W = 7;
	localparam int MEM_AW = 10;
	localparam int SRC_W = 8;

	// ****************************************
	// time base
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 100000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [31:0] TICKS_PER_SEC = 32'h0000000a;
	localparam logic [31:0] TICKS_PER_MIN = 32'h00000258;
	localparam logic [31:0] TICKS_PER_HOUR = 32'h00008ca0;

	// ****************************************
	// register offsets inside one generator window
	// ****************************************
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_SRC = 6'h04;
	localparam logic [5:0] OFF_IDLE = 6'h08;
	localparam logic [5:0] OFF_LOOPCNT = 6'h0c;
	localparam logic [5:0] OFF_RETSEC = 6'h10;
	localparam logic [5:0] OFF_NSEC = 6'h14;
	localparam logic [5:0] OFF_SECSEL = 6'h18;
	localparam logic [5:0] OFF_SECTIME = 6'h1c;
	localparam logic [5:0] OFF_SECVAL = 6'h20;
	localparam logic [5:0] OFF_STATUS = 6'h24;
	localparam logic [5:0] OFF_OUT = 6'h28;
	localparam int GEN_SHIFT = 6;

	// ****************************************
	// field codes and reset values
	// ****************************************
	localparam logic [2:0] TRIG_OFF = 3'h0;
	localparam logic [2:0] TRIG_GATE = 3'h1;
	localparam logic [2:0] TRIG_ONCE = 3'h2;
	localparam logic [2:0] TRIG_RETRIG = 3'h3;
	localparam logic [2:0] PAUSE_OFF = 3'h0;
	localparam logic [2:0] PAUSE_HIGH = 3'h1;
	localparam logic [2:0] PAUSE_LOW = 3'h2;
	localparam logic [2:0] PAUSE_RISE = 3'h3;
	localparam logic [2:0] PAUSE_FALL = 3'h4;
	localparam logic [1:0] LOOP_OFF = 2'h0;
	localparam logic [1:0] LOOP_COUNT = 2'h1;
	localparam logic [1:0] LOOP_CHAN = 2'h2;
	localparam logic [1:0] LOOP_INF = 2'h3;
	localparam logic [1:0] UNIT_SEC = 2'h0;
	localparam logic [1:0] UNIT_MIN = 2'h1;
	localparam logic SHAPE_CONST = 1'h0;
	localparam logic [31:0] RST_REG = 32'h00000000;

	typedef enum logic {ST_IDLE, ST_RUN} psg_state_t;
endpackage

/* psg_top.sv */
// The APB register port and the register offsets were left to the implementer.
module psg_top #(
	parameter int NUM_CHAN = 16,
	parameter int TICK_CYC = psg_pkg::TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [NUM_CHAN*psg_pkg::VAL_W-1:0] chan_val_in,
	output logic [psg_pkg::NUM_GEN*psg_pkg::VAL_W-1:0] prof_out
);
	import psg_pkg::*;

	// ****************************************
	// configuration storage
	// ****************************************
	logic [2:0] trig_mode_r [NUM_GEN];
	logic [2:0] pause_mode_r [NUM_GEN];
	logic [1:0] loop_mode_r [NUM_GEN];
	logic [SRC_W-1:0] trig_src_r [NUM_GEN];
	logic [SRC_W-1:0] pause_src_r [NUM_GEN];
	logic [SRC_W-1:0] loop_src_r [NUM_GEN];
	logic [VAL_W-1:0] idle_r [NUM_GEN];
	logic [15:0] loop_cnt_r [NUM_GEN];
	logic [SEC_W-1:0] ret_sec_r [NUM_GEN];
	logic [SEC_W-1:0] nsec_r [NUM_GEN];
	logic [SEC_W-1:0] sec_sel_r [NUM_GEN];
	logic [15:0] sec_dur_r [NUM_GEN*MAX_SEC];
	logic [1:0] sec_unit_r [NUM_GEN*MAX_SEC];
	logic sec_shape_r [NUM_GEN*MAX_SEC];
	logic [VAL_W-1:0] sec_fin_r [NUM_GEN*MAX_SEC];

	// generator state seen by the register reads
	logic [NUM_GEN-1:0] run_w;
	logic [NUM_GEN-1:0] halt_w;
	logic [SEC_W-1:0] sec_w [NUM_GEN];
	logic [15:0] cyc_w [NUM_GEN];

	// ****************************************
	// apb slave
	// ****************************************
	logic [2:0] gidx;
	logic [5:0] roff;
	logic [MEM_AW-1:0] wr_idx;
	logic addr_ok;
	logic [31:0] rd_data;
	logic wr_en;

	assign gidx = paddr_in[GEN_SHIFT+2:GEN_SHIFT];
	assign roff = paddr_in[GEN_SHIFT-1:0];
	assign wr_idx = MEM_AW'(gidx * MAX_SEC + sec_sel_r[gidx]);
	assign wr_en = psel_in && penable_in && pready_out && pwrite_in && addr_ok;

	always_comb begin
		addr_ok = (paddr_in[31:GEN_SHIFT+3] == '0) && (roff <= OFF_OUT) && (roff[1:0] == 2'h0);
		rd_data = RST_REG;
		case (roff)
			OFF_CTRL: rd_data = {24'h0, loop_mode_r[gidx], pause_mode_r[gidx], trig_mode_r[gidx]};
			OFF_SRC: rd_data = {8'h0, loop_src_r[gidx], pause_src_r[gidx], trig_src_r[gidx]};
			OFF_IDLE: rd_data = {16'h0, idle_r[gidx]};
			OFF_LOOPCNT: rd_data = {16'h0, loop_cnt_r[gidx]};
			OFF_RETSEC: rd_data = {25'h0, ret_sec_r[gidx]};
			OFF_NSEC: rd_data = {25'h0, nsec_r[gidx]};
			OFF_SECSEL: rd_data = {25'h0, sec_sel_r[gidx]};
			OFF_SECTIME: rd_data = {13'h0, sec_shape_r[wr_idx], sec_unit_r[wr_idx], sec_dur_r[wr_idx]};
			OFF_SECVAL: rd_data = {16'h0, sec_fin_r[wr_idx]};
			OFF_STATUS: rd_data = {cyc_w[gidx], 7'h0, sec_w[gidx], halt_w[gidx], run_w[gidx]};
			OFF_OUT: rd_data = {16'h0, prof_out[gidx*VAL_W +: VAL_W]};
			default: rd_data = RST_REG;
		endcase
	end

	// one wait-free access phase: pready rises in the cycle after setup
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= RST_REG;
		end else begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !addr_ok;
			if (psel_in && !penable_in && !pwrite_in && addr_ok) begin
				prdata_out <= rd_data;
			end else if (psel_in && !penable_in) begin
				prdata_out <= RST_REG;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_GEN; i++) begin
				trig_mode_r[i] <= TRIG_OFF;
				pause_mode_r[i] <= PAUSE_OFF;
				loop_mode_r[i] <= LOOP_OFF;
				trig_src_r[i] <= '0;
				pause_src_r[i] <= '0;
				loop_src_r[i] <= '0;
				idle_r[i] <= '0;
				loop_cnt_r[i] <= '0;
				ret_sec_r[i] <= '0;
				nsec_r[i] <= '0;
				sec_sel_r[i] <= '0;
			end
		end else if (wr_en) begin
			case (roff)
				OFF_CTRL: begin
					trig_mode_r[gidx] <= pwdata_in[2:0];
					pause_mode_r[gidx] <= pwdata_in[5:3];
					loop_mode_r[gidx] <= pwdata_in[7:6];
				end
				OFF_SRC: begin
					trig_src_r[gidx] <= pwdata_in[7:0];
					pause_src_r[gidx] <= pwdata_in[15:8];
					loop_src_r[gidx] <= pwdata_in[23:16];
				end
				OFF_IDLE: idle_r[gidx] <= pwdata_in[VAL_W-1:0];
				OFF_LOOPCNT: loop_cnt_r[gidx] <= pwdata_in[15:0];
				OFF_NSEC: nsec_r[gidx] <= (pwdata_in[SEC_W-1:0] > SEC_W'(MAX_SEC)) ?
					SEC_W'(MAX_SEC) : pwdata_in[SEC_W-1:0];
				OFF_RETSEC: ret_sec_r[gidx] <= pwdata_in[SEC_W-1:0];
				OFF_SECSEL: sec_sel_r[gidx] <= (pwdata_in[SEC_W-1:0] >= SEC_W'(MAX_SEC)) ?
					SEC_W'(MAX_SEC - 1) : pwdata_in[SEC_W-1:0];
				default: ;
			endcase
		end
	end

	// section table has no reset; software fills it before use
	always_ff @(posedge ref_clk_in) begin
		if (wr_en && roff == OFF_SECTIME) begin
			sec_dur_r[wr_idx] <= pwdata_in[15:0];
			sec_unit_r[wr_idx] <= pwdata_in[17:16];
			sec_shape_r[wr_idx] <= pwdata_in[18];
		end
		if (wr_en && roff == OFF_SECVAL) begin
			sec_fin_r[wr_idx] <= pwdata_in[VAL_W-1:0];
		end
	end

	// ****************************************
	// shared time base
	// ****************************************
	logic [31:0] tick_cnt_r;
	logic tick_r;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 32'(TICK_CYC - 1));
			tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_r + 32'h1;
		end
	end

	function automatic logic signed [VAL_W-1:0] chan_get(input logic [SRC_W-1:0] s);
		chan_get = '0;
		if (int'(s) < NUM_CHAN) begin
			chan_get = $signed(chan_val_in[s*VAL_W +: VAL_W]);
		end
	endfunction

	// ****************************************
	// generators
	// ****************************************
	// eight instances
	for (genvar g = 0; g < NUM_GEN; g++) begin : gen_g
		psg_state_t st_r;
		logic [SEC_W-1:0] sec_r;
		logic [31:0] tcnt_r;
		logic [33:0] err_r;
		logic signed [VAL_W-1:0] out_r;
		logic signed [VAL_W-1:0] start_r;
		logic [15:0] cyc_r;
		logic tprev_r;
		logic pprev_r;
		logic paused_r;
		logic reentry_r;
		logic tpos, ppos, trig_edge, p_edge, lvl_halt, halt, start_req, stop_req;
		logic [MEM_AW-1:0] mi, m0;
		logic signed [VAL_W-1:0] fin, lim;
		logic [31:0] len, mult;
		logic [16:0] mag;
		logic last_tick, loop_go;
		logic [15:0] cyc_nxt;

		assign tpos = chan_get(trig_src_r[g]) > 0;
		assign ppos = chan_get(pause_src_r[g]) > 0;
		assign lim = chan_get(loop_src_r[g]);
		assign trig_edge = tpos && !tprev_r;
		assign mi = MEM_AW'(g * MAX_SEC + sec_r);
		assign m0 = MEM_AW'(g * MAX_SEC);
		assign fin = $signed(sec_fin_r[mi]);
		assign mult = (sec_unit_r[mi] == UNIT_SEC) ? TICKS_PER_SEC :
			(sec_unit_r[mi] == UNIT_MIN) ? TICKS_PER_MIN : TICKS_PER_HOUR;
		assign len = 32'({16'h0, sec_dur_r[mi]} * mult);
		assign mag = (fin > start_r) ? 17'(fin - start_r) : 17'(start_r - fin);
		assign last_tick = tick_r && (tcnt_r + 32'h1 >= len);
		assign cyc_nxt = cyc_r + 16'h1;

		assign lvl_halt = (pause_mode_r[g] == PAUSE_HIGH && ppos) ||
			(pause_mode_r[g] == PAUSE_LOW && !ppos);
		assign p_edge = (pause_mode_r[g] == PAUSE_RISE && ppos && !pprev_r) ||
			(pause_mode_r[g] == PAUSE_FALL && !ppos && pprev_r);
		assign halt = lvl_halt || (paused_r && (pause_mode_r[g] == PAUSE_RISE ||
			pause_mode_r[g] == PAUSE_FALL));

		assign start_req = !lvl_halt && nsec_r[g] != '0 && (
			(trig_mode_r[g] == TRIG_GATE && tpos && st_r == ST_IDLE) ||
			(trig_mode_r[g] == TRIG_ONCE && trig_edge && st_r == ST_IDLE) ||
			(trig_mode_r[g] == TRIG_RETRIG && trig_edge));
		assign stop_req = (trig_mode_r[g] == TRIG_GATE && !tpos) ||
			!(trig_mode_r[g] inside {TRIG_GATE, TRIG_ONCE, TRIG_RETRIG});

		always_comb begin
			case (loop_mode_r[g])
				LOOP_COUNT: loop_go = cyc_nxt < loop_cnt_r[g];
				LOOP_CHAN: loop_go = $signed({1'b0, cyc_nxt}) < $signed(lim);
				LOOP_INF: loop_go = 1'b1;
				default: loop_go = 1'b0;
			endcase
		end

		always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				tprev_r <= 1'b0;
				pprev_r <= 1'b0;
				paused_r <= 1'b0;
			end else begin
				tprev_r <= tpos;
				pprev_r <= ppos;
				if (pause_mode_r[g] != PAUSE_RISE && pause_mode_r[g] != PAUSE_FALL) begin
					paused_r <= 1'b0;
				end else if (p_edge) begin
					paused_r <= !paused_r;
				end
			end
		end

		always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				st_r <= ST_IDLE;
				sec_r <= '0;
				tcnt_r <= '0;
				err_r <= '0;
				out_r <= '0;
				start_r <= '0;
				cyc_r <= '0;
				reentry_r <= 1'b0;
			end else if (start_req) begin
				st_r <= ST_RUN;
				sec_r <= '0;
				tcnt_r <= '0;
				err_r <= '0;
				start_r <= $signed(idle_r[g]);
				cyc_r <= '0;
				reentry_r <= 1'b0;
			end else if (lvl_halt) begin
				out_r <= (sec_shape_r[m0] == SHAPE_CONST && nsec_r[g] != '0) ?
					$signed(sec_fin_r[m0]) : $signed(idle_r[g]);
			end else begin
				case (st_r)
					ST_IDLE: begin
						out_r <= $signed(idle_r[g]);
					end
					ST_RUN: begin
						if (stop_req) begin
							st_r <= ST_IDLE;
							out_r <= $signed(idle_r[g]);
						end else if (!halt) begin
							if (sec_shape_r[mi] == SHAPE_CONST) begin
								if (!reentry_r) begin
									out_r <= fin;
								end
							end else if (err_r >= 34'(len) && len != '0 && out_r != fin) begin
								out_r <= (fin > start_r) ? out_r + 16'sh1 : out_r - 16'sh1;
								err_r <= err_r - 34'(len);
							end else if (tick_r) begin
								err_r <= err_r + 34'(mag);
							end
							if (tick_r) begin
								tcnt_r <= tcnt_r + 32'h1;
								reentry_r <= 1'b0;
							end
							if (last_tick || len == '0) begin
								out_r <= fin;
								start_r <= fin;
								tcnt_r <= '0;
								err_r <= '0;
								reentry_r <= 1'b0;
								if (sec_r + 7'h1 < nsec_r[g]) begin
									sec_r <= sec_r + 7'h1;
								end else if (loop_go && ret_sec_r[g] < nsec_r[g]) begin
									sec_r <= ret_sec_r[g];
									cyc_r <= cyc_nxt;
									reentry_r <= 1'b1;
								end else begin
									st_r <= ST_IDLE;
									cyc_r <= cyc_nxt;
								end
							end
						end
					end
					default: st_r <= ST_IDLE;
				endcase
			end
		end

		assign run_w[g] = (st_r == ST_RUN);
		assign halt_w[g] = halt;
		assign sec_w[g] = sec_r;
		assign cyc_w[g] = cyc_r;

		always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				prof_out[g*VAL_W +: VAL_W] <= '0;
			end else begin
				prof_out[g*VAL_W +: VAL_W] <= out_r;
			end
		end
	end
endmodule

/* psg_chan_model.sv */
module psg_chan_model import psg_pkg::*; #(
	parameter int NUM_CHAN = 16
) (
	input wire logic clk_in,
	output logic [NUM_CHAN*VAL_W-1:0] chan_val_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// logical channel values
	// ****************************************
	initial chan_val_out = '0;

	// values move only just after an edge, like any clocked source would
	task automatic set_chan(input int idx, input logic [VAL_W-1:0] v);
		@(posedge clk_in);
		chan_val_out[idx*VAL_W +: VAL_W] <= v;
	endtask
endmodule

/* psg_top_asserts.sv */
module psg_top_asserts import psg_pkg::*; #(
	parameter int NUM_CHAN = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [NUM_CHAN*VAL_W-1:0] chan_val_in,
	input wire logic [NUM_GEN*VAL_W-1:0] prof_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// bus checks and output-after-reset check
	// ****************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence setup_s;
		psel_in && !penable_in;
	endsequence
	sequence bad_s;
		setup_s ##0 (|paddr_in[31:9] || |paddr_in[1:0] || paddr_in[5:0] > OFF_OUT);
	endsequence

	a_ready_after_setup: assert property (setup_s |=> pready_out)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	a_ready_needs_setup: assert property (pready_out |-> $past(psel_in && !penable_in))
		else $error("ready without setup");
	a_err_on_bad: assert property (bad_s |=> pslverr_out && pready_out)
		else $error("no error on unmapped address");
	a_no_err_good: assert property (setup_s ##0 !(|paddr_in[31:9] || |paddr_in[1:0]
		|| paddr_in[5:0] > OFF_OUT) |=> !pslverr_out)
		else $error("error on mapped address");
	a_bad_read_zero: assert property (bad_s ##0 !pwrite_in |=> prdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_idle_after_reset: assert property ($rose(rst_b_in) |-> prof_out == '0)
		else $error("output not idle after reset");
endmodule

bind psg_top psg_top_asserts #(.NUM_CHAN(NUM_CHAN)) chk_u (.ref_clk_in, .rst_b_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
	.pready_out, .pslverr_out, .chan_val_in, .prof_out);

/* psg_top_test.sv */
module psg_top_test import psg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NCH = 16;
	// a short tick keeps one second at a hundred clocks
	localparam int TCY = 10;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NCH*VAL_W-1:0] chv;
	logic [NUM_GEN*VAL_W-1:0] prof;
	logic [31:0] rd;
	logic er;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	psg_chan_model #(.NUM_CHAN(NCH)) model_u (.clk_in(clk), .chan_val_out(chv));
	psg_top #(.NUM_CHAN(NCH), .TICK_CYC(TCY)) dut_u (.ref_clk_in(clk), .rst_b_in(rst_b),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .chan_val_in(chv), .prof_out(prof));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic report_and_stop();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the bench timeout ends a wait for ready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int g, input logic [5:0] off, input logic [31:0] d);
		apb(1'b1, 32'(g * 64) + {26'h0, off}, d);
	endtask

	task automatic sec(input int g, input logic [31:0] tm, input logic [31:0] v);
		wr(g, OFF_NSEC, 32'h1);
		wr(g, OFF_SECSEL, 32'h0);
		wr(g, OFF_SECTIME, tm);
		wr(g, OFF_SECVAL, v);
	endtask

	function automatic logic [31:0] out(input int g);
		return {16'h0, prof[g*VAL_W +: VAL_W]};
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_regs();
		apb(1'b0, 32'h1c0, 32'h0);
		check({31'h0, er}, 32'h0);
		check(rd, RST_REG);
		apb(1'b0, 32'h200, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
		wr(0, OFF_IDLE, 32'h3);
		apb(1'b0, {26'h0, OFF_IDLE}, 32'h0);
		check(rd, 32'h3);
		repeat (4) @(posedge clk);
		check(out(0), 32'h3);
	endtask

	task automatic s_once();
		sec(0, 32'h1, 32'h5);
		wr(0, OFF_SRC, 32'h200);
		wr(0, OFF_CTRL, {29'h0, TRIG_ONCE});
		model_u.set_chan(0, 16'h1);
		repeat (5) @(posedge clk);
		check(out(0), 32'h5);
		repeat (50) @(posedge clk);
		model_u.set_chan(0, 16'h0);
		model_u.set_chan(0, 16'h1);
		// a restart here would still show the section level below
		repeat (60) @(posedge clk);
		check(out(0), 32'h3);
		check(out(0), 32'h3);
	endtask

	task automatic s_gate();
		sec(1, 32'h10001, 32'h9);
		wr(1, OFF_IDLE, 32'h7);
		wr(1, OFF_SRC, 32'h1);
		wr(1, OFF_CTRL, {29'h0, TRIG_GATE});
		model_u.set_chan(1, 16'h1);
		repeat (5) @(posedge clk);
		check(out(1), 32'h9);
		model_u.set_chan(1, 16'hfffe);
		repeat (4) @(posedge clk);
		check(out(1), 32'h7);
	endtask

	task automatic s_pause();
		model_u.set_chan(0, 16'h0);
		wr(0, OFF_CTRL, {26'h0, PAUSE_HIGH, TRIG_ONCE});
		model_u.set_chan(2, 16'h1);
		repeat (4) @(posedge clk);
		check(out(0), 32'h5);
		model_u.set_chan(0, 16'h1);
		repeat (4) @(posedge clk);
		check(out(0), 32'h5);
		model_u.set_chan(2, 16'h0);
		repeat (4) @(posedge clk);
		check(out(0), 32'h3);
		wr(0, OFF_CTRL, {26'h0, PAUSE_LOW, TRIG_ONCE});
		repeat (4) @(posedge clk);
		check(out(0), 32'h5);
		model_u.set_chan(2, 16'h1);
		repeat (4) @(posedge clk);
		check(out(0), 32'h3);
	endtask

	task automatic s_retrig();
		sec(2, 32'h1, 32'h6);
		wr(2, OFF_SRC, 32'h203);
		wr(2, OFF_CTRL, {29'h0, TRIG_RETRIG});
		model_u.set_chan(3, 16'h1);
		repeat (5) @(posedge clk);
		check(out(2), 32'h6);
		// pause source is positive but the pause function is off
		apb(1'b0, 32'ha4, 32'h0);
		check({30'h0, rd[1:0]}, 32'h1);
		repeat (52) @(posedge clk);
		model_u.set_chan(3, 16'h0);
		model_u.set_chan(3, 16'h1);
		// the first run alone would be over by now
		repeat (60) @(posedge clk);
		check(out(2), 32'h6);
		repeat (60) @(posedge clk);
		check(out(2), 32'h0);
	endtask

	task automatic s_edge();
		sec(3, 32'h1, 32'h4);
		wr(3, OFF_SRC, 32'h504);
		wr(3, OFF_CTRL, {26'h0, PAUSE_RISE, TRIG_ONCE});
		model_u.set_chan(4, 16'h1);
		model_u.set_chan(5, 16'h1);
		apb(1'b0, 32'he4, 32'h0);
		check({30'h0, rd[1:0]}, 32'h3);
		repeat (150) @(posedge clk);
		check(out(3), 32'h4);
		model_u.set_chan(5, 16'h0);
		model_u.set_chan(5, 16'h1);
		repeat (120) @(posedge clk);
		check(out(3), 32'h0);
		wr(3, OFF_CTRL, {26'h0, PAUSE_FALL, TRIG_ONCE});
		model_u.set_chan(5, 16'h0);
		model_u.set_chan(4, 16'h0);
		model_u.set_chan(4, 16'h1);
		apb(1'b0, 32'he4, 32'h0);
		check({30'h0, rd[1:0]}, 32'h3);
		model_u.set_chan(5, 16'h1);
		model_u.set_chan(5, 16'h0);
		repeat (5) @(posedge clk);
		check(out(3), 32'h4);
	endtask

	task automatic s_loop();
		int n;
		wr(4, OFF_NSEC, 32'h2);
		wr(4, OFF_SECSEL, 32'h0);
		wr(4, OFF_SECTIME, 32'h1);
		wr(4, OFF_SECVAL, 32'h11);
		wr(4, OFF_SECSEL, 32'h1);
		wr(4, OFF_SECTIME, 32'h1);
		wr(4, OFF_SECVAL, 32'h22);
		wr(4, OFF_LOOPCNT, 32'h2);
		wr(4, OFF_RETSEC, 32'h0);
		wr(4, OFF_SRC, 32'h6);
		wr(4, OFF_CTRL, {24'h0, LOOP_COUNT, PAUSE_OFF, TRIG_ONCE});
		model_u.set_chan(6, 16'h1);
		repeat (5) @(posedge clk);
		check(out(4), 32'h11);
		while (out(4) !== 32'h22) @(posedge clk);
		n = 0;
		while (out(4) === 32'h22) begin
			@(posedge clk);
			n++;
		end
		// ten ticks of section plus one tick of hold on re-entry
		check(32'(n), 32'(11 * TCY));
		check(out(4), 32'h11);
		repeat (250) @(posedge clk);
		check(out(4), 32'h0);
		apb(1'b0, 32'h124, 32'h0);
		check({16'h0, rd[31:16]}, 32'h2);
		model_u.set_chan(7, 16'h1);
		wr(4, OFF_SRC, 32'h70006);
		wr(4, OFF_CTRL, {24'h0, LOOP_CHAN, PAUSE_OFF, TRIG_ONCE});
		model_u.set_chan(6, 16'h0);
		model_u.set_chan(6, 16'h1);
		repeat (150) @(posedge clk);
		check(out(4), 32'h22);
		repeat (110) @(posedge clk);
		check(out(4), 32'h0);
		apb(1'b0, 32'h124, 32'h0);
		check({16'h0, rd[31:16]}, 32'h1);
	endtask

	task automatic s_slope();
		wr(5, OFF_SRC, 32'h8);
		wr(5, OFF_CTRL, {29'h0, TRIG_ONCE});
		model_u.set_chan(8, 16'h1);
		apb(1'b0, 32'h164, 32'h0);
		check({31'h0, rd[0]}, 32'h0);
		model_u.set_chan(8, 16'h0);
		sec(5, 32'h40001, 32'h14);
		model_u.set_chan(8, 16'h1);
		// first step follows the first tick, which fixes the phase
		while (out(5) === 32'h0) @(posedge clk);
		repeat (45) @(posedge clk);
		check(out(5), 32'ha);
		repeat (44) @(posedge clk);
		check(out(5), 32'h14);
		@(posedge clk);
		check(out(5), 32'h0);
	endtask

	// ****************************************
	// run control
	// ****************************************
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		s_regs();
		s_once();
		s_gate();
		s_pause();
		s_retrig();
		s_edge();
		s_loop();
		s_slope();
		report_and_stop();
	end
endmodule
